// ==== design/swd_top.sv ====
/*
 * Software watchdog: 32-bit down counter stepped by the watchdog clock pin,
 * reloaded by software, raising a system reset when it runs out.
 * Assumes all inputs, the watchdog clock pin included, are synchronous to
 * clk_in and that the watchdog clock runs well below half of clk_in.
 */
`timescale 1ns/1ps
module swd_top
    import swd_pkg::*;
#(
    parameter int CNT_W = swd_pkg::SWD_CNT_W
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    // watchdog clock pin
    input  wire logic             watchdog_clock_input_in,
    // software control
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] load_value_in,
    input  wire logic             enable_in,
    input  wire logic             disable_in,
    input  wire logic             reload_in,
    // status
    output logic                  loaded_out,
    output logic                  running_out,
    output logic                  expired_out,
    output logic [CNT_W-1:0]      count_out,
    // reset outputs
    output logic                  watchdog_reset_output_n_out,
    output logic                  core_reset_out,
    output logic                  periph_reset_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    swd_cnt_if #(.W(CNT_W)) cnt_if ();

    swd_state_e                 state_r;
    swd_state_e                 state_nxt;
    logic [CNT_W-1:0]           reload_val_r;
    logic [CNT_W-1:0]           reload_val_nxt;
    logic                       expired_r;
    logic                       expired_nxt;
    logic                       wclk_prev_r;
    logic                       wclk_prev_nxt;
    logic                       wclk_rise;
    logic [SWD_PULSE_W-1:0]     pulse_r;
    logic [SWD_PULSE_W-1:0]     pulse_nxt;
    logic                       pulse_done;
    logic                       fire_r;
    logic                       fire_nxt;
    logic                       loaded_r;
    logic                       loaded_nxt;
    logic                       running_r;
    logic                       running_nxt;

    // ****************************************************************
    // counter
    // ****************************************************************
    swd_counter i_swd_counter (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .cnt_if    (cnt_if.cnt)
    );

    // ****************************************************************
    // watchdog clock pin edge
    // ****************************************************************
    // pin idles low, so a low last sample after reset
    // gives no false step straight after reset
    always_comb begin
        wclk_prev_nxt = watchdog_clock_input_in;
        wclk_rise     = watchdog_clock_input_in & ~wclk_prev_r;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wclk_prev_r <= 1'b0;
        end else begin
            wclk_prev_r <= wclk_prev_nxt;
        end
    end

    // ****************************************************************
    // control
    // ****************************************************************
    always_comb begin
        state_nxt      = state_r;
        reload_val_nxt = reload_val_r;
        expired_nxt    = expired_r;
        cnt_if.load    = 1'b0;
        cnt_if.value   = reload_val_r;
        cnt_if.tick    = 1'b0;

        case (state_r)
            SWD_ST_EMPTY: begin
                // enable without a count is ignored
                if (load_in) begin
                    reload_val_nxt = load_value_in;
                    cnt_if.value   = load_value_in;
                    cnt_if.load    = 1'b1;
                    state_nxt      = SWD_ST_ARMED;
                end
            end
            SWD_ST_ARMED: begin
                if (load_in) begin
                    reload_val_nxt = load_value_in;
                    cnt_if.value   = load_value_in;
                    cnt_if.load    = 1'b1;
                end else if (enable_in) begin
                    state_nxt   = SWD_ST_RUN;
                    expired_nxt = 1'b0;
                end
            end
            SWD_ST_RUN: begin
                if (disable_in) begin
                    state_nxt = SWD_ST_ARMED;
                end else if (cnt_if.zero) begin
                    // expiry wins over a reload in the same cycle
                    state_nxt   = SWD_ST_FIRE;
                    expired_nxt = 1'b1;
                end else if (load_in) begin
                    reload_val_nxt = load_value_in;
                    cnt_if.value   = load_value_in;
                    cnt_if.load    = 1'b1;
                end else if (reload_in) begin
                    cnt_if.load = 1'b1;
                end else begin
                    cnt_if.tick = wclk_rise;
                end
            end
            SWD_ST_FIRE: begin
                // held until the pulse is done, then empty; a fresh load and a new enable are then needed
                if (pulse_done) begin
                    state_nxt = SWD_ST_EMPTY;
                end
            end
            default: begin
                state_nxt = SWD_ST_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r      <= SWD_ST_EMPTY;
            reload_val_r <= SWD_CNT_RST;
            expired_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            reload_val_r <= reload_val_nxt;
            expired_r    <= expired_nxt;
        end
    end

    // ****************************************************************
    // reset pulse
    // ****************************************************************
    // width counted in whole system clocks, so it does not depend on
    // the watchdog clock, which may be stopped once expiry is seen
    always_comb begin
        pulse_done = (pulse_r == SWD_PULSE_LAST);
        pulse_nxt  = SWD_PULSE_RST;
        if ((state_r == SWD_ST_FIRE) && !pulse_done) begin
            pulse_nxt = pulse_r + 1'b1;
        end
        fire_nxt   = (state_nxt == SWD_ST_FIRE);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pulse_r <= SWD_PULSE_RST;
            fire_r  <= 1'b0;
        end else begin
            pulse_r <= pulse_nxt;
            fire_r  <= fire_nxt;
        end
    end

    // ****************************************************************
    // status
    // ****************************************************************
    always_comb begin
        loaded_nxt  = (state_nxt == SWD_ST_ARMED) || (state_nxt == SWD_ST_RUN);
        running_nxt = (state_nxt == SWD_ST_RUN);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            loaded_r  <= 1'b0;
            running_r <= 1'b0;
        end else begin
            loaded_r  <= loaded_nxt;
            running_r <= running_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // one registered source, so core and peripherals leave reset together
    assign core_reset_out              = fire_r;
    assign periph_reset_out            = fire_r;
    assign watchdog_reset_output_n_out = ~fire_r;
    assign loaded_out                  = loaded_r;
    assign running_out                 = running_r;
    assign expired_out                 = expired_r;
    assign count_out                   = cnt_if.count;

endmodule

// ==== design/swd_pkg.sv ====
/*
 * Package for the software watchdog: control states, widths, reset values
 * and the length of the reset pulse raised on expiry.
 * Assumes a single 40 MHz system clock and no software-visible register map.
 */
package swd_pkg;

    // ****************************************************************
    // widths and reset values
    // ****************************************************************
    localparam int          SWD_CNT_W       = 32;
    localparam logic [31:0] SWD_CNT_RST     = 32'h0000_0000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SWD_CLK_PERIOD_PS = 25000;
    // least width of the reset pulse, as a time
    localparam int SWD_RST_PULSE_NS  = 1000;
    // least time rounds up to whole cycles
    localparam int SWD_RST_PULSE_CYC =
        (SWD_RST_PULSE_NS * 1000 + SWD_CLK_PERIOD_PS - 1) / SWD_CLK_PERIOD_PS;
    localparam int SWD_PULSE_W       = 8;
    localparam logic [SWD_PULSE_W-1:0] SWD_PULSE_LAST = SWD_PULSE_W'(SWD_RST_PULSE_CYC - 1);
    localparam logic [SWD_PULSE_W-1:0] SWD_PULSE_RST  = 8'h00;

    // ****************************************************************
    // control states
    // ****************************************************************
    typedef enum logic [1:0] {
        SWD_ST_EMPTY = 2'b00,   // no count loaded
        SWD_ST_ARMED = 2'b01,   // count loaded, not counting
        SWD_ST_RUN   = 2'b10,   // counting down
        SWD_ST_FIRE  = 2'b11    // driving the system reset
    } swd_state_e;

endpackage

// ==== design/swd_cnt_if.sv ====
/*
 * Carrier between the watchdog control and its down counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface swd_cnt_if #(
    parameter int W = 32
);
    logic         tick;
    logic         load;
    logic [W-1:0] value;
    logic [W-1:0] count;
    logic         zero;

    modport ctl (output tick, output load, output value, input count, input zero);
    modport cnt (input tick, input load, input value, output count, output zero);
endinterface

// ==== design/swd_counter.sv ====
/*
 * Down counter of the watchdog: loads a value, steps down by one per tick until zero,
 * and flags zero.
 * Assumes load and tick come from the control in the same clock domain.
 */
`timescale 1ns/1ps
module swd_counter
    import swd_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    // control side
    swd_cnt_if.cnt    cnt_if
);

    logic [$bits(cnt_if.count)-1:0] count_r;
    logic [$bits(cnt_if.count)-1:0] count_nxt;

    // ****************************************************************
    // count
    // ****************************************************************
    always_comb begin
        count_nxt = count_r;
        if (cnt_if.load) begin
            count_nxt = cnt_if.value;
        end else if (cnt_if.tick && count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_r <= SWD_CNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign cnt_if.count = count_r;
    assign cnt_if.zero  = (count_r == '0);

endmodule

// ==== verif/swd_properties.sv ====
/*
 * Concurrent checks on the watchdog top-level ports.
 * Assumes one clock domain, clk_in, and the async active-low reset.
 */
`timescale 1ns/1ps
module swd_properties
    import swd_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic             clk_in,
    input wire logic             arst_n_in,
    input wire logic             watchdog_clock_input_in,
    input wire logic             load_in,
    input wire logic [CNT_W-1:0] load_value_in,
    input wire logic             enable_in,
    input wire logic             disable_in,
    input wire logic             reload_in,
    input wire logic             loaded_out,
    input wire logic             running_out,
    input wire logic             expired_out,
    input wire logic [CNT_W-1:0] count_out,
    input wire logic             watchdog_reset_output_n_out,
    input wire logic             core_reset_out,
    input wire logic             periph_reset_out
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire quiet = !load_in && !reload_in && !disable_in;
    a_fire_on_zero: assert property (running_out && count_out == 0 && !disable_in
        |=> core_reset_out && expired_out)
        else $error("no reset after count reached zero");
    a_core_periph_same: assert property (core_reset_out == periph_reset_out)
        else $error("core and peripheral resets differ");
    a_pin_follows: assert property (watchdog_reset_output_n_out == !core_reset_out)
        else $error("reset-out pin disagrees with core reset");
    a_step_on_edge: assert property (running_out && quiet && count_out != 0
        && $rose(watchdog_clock_input_in) |=> count_out == $past(count_out) - 1)
        else $error("count did not step down on watchdog clock edge");
    a_hold_no_edge: assert property (running_out && quiet && count_out != 0
        && !$rose(watchdog_clock_input_in) |=> $stable(count_out))
        else $error("count moved without watchdog clock edge");
    a_pulse_width: assert property ($rose(core_reset_out) |-> ##39 core_reset_out ##1 !core_reset_out)
        else $error("reset pulse width wrong");
    a_disabled_after: assert property ($fell(core_reset_out) |-> !loaded_out && !running_out)
        else $error("watchdog not idle after expiry");
    a_load_taken: assert property (load_in && !core_reset_out && !disable_in
        && !(running_out && count_out == 0) |=> loaded_out && count_out == $past(load_value_in))
        else $error("load not taken");
    a_enable_starts: assert property (enable_in && loaded_out && !running_out
        && !load_in && !core_reset_out |=> running_out)
        else $error("enable did not start counting");
    a_idle_hold: assert property (!running_out && !load_in |=> $stable(count_out))
        else $error("count moved while not counting");
    c_fire: cover property ($rose(core_reset_out));
    c_reload: cover property (running_out && reload_in);
    c_disable: cover property (running_out && disable_in);
endmodule
bind swd_top swd_properties #(.CNT_W(CNT_W)) i_swd_properties (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .watchdog_clock_input_in(watchdog_clock_input_in), .load_in(load_in), .load_value_in(load_value_in),
    .enable_in(enable_in), .disable_in(disable_in), .reload_in(reload_in), .loaded_out(loaded_out),
    .running_out(running_out), .expired_out(expired_out), .count_out(count_out),
    .watchdog_reset_output_n_out(watchdog_reset_output_n_out), .core_reset_out(core_reset_out),
    .periph_reset_out(periph_reset_out));

// ==== verif/test_swd_top.sv ====
/*
 * Self-checking bench for the watchdog top level.
 * Assumes the design package and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end
module test_swd_top;
    import swd_pkg::*;
    logic        clk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        wdclk = 1'b0;
    logic        ld = 1'b0, en = 1'b0, dis = 1'b0, rl = 1'b0;
    logic [31:0] val = 32'h0;
    logic        loaded, running, expired, rst_n, core, periph;
    logic [31:0] count;
    int          err_count = 0, check_count = 0, cyc_count = 0;
    swd_top i_swd_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .watchdog_clock_input_in(wdclk),
        .load_in(ld), .load_value_in(val), .enable_in(en), .disable_in(dis), .reload_in(rl),
        .loaded_out(loaded), .running_out(running), .expired_out(expired), .count_out(count),
        .watchdog_reset_output_n_out(rst_n), .core_reset_out(core), .periph_reset_out(periph));
    // ****************************************************************
    // helpers and scenarios
    // ****************************************************************
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc_count++;
        if (cyc_count == 4000) begin
            err_count++;
            close_out();
        end
    end
    // kind: 0 load, 1 enable, 2 disable, 3 reload; settled after return
    task automatic op(input int k, input logic [31:0] v);
        @(posedge clk_in);
        val <= v;
        ld <= (k == 0);
        en <= (k == 1);
        dis <= (k == 2);
        rl <= (k == 3);
        @(posedge clk_in);
        {ld, en, dis, rl} <= 4'h0;
        #1;
    endtask
    // one watchdog clock period, low at least one clk either side
    task automatic tick();
        @(posedge clk_in);
        wdclk <= 1'b1;
        @(posedge clk_in);
        wdclk <= 1'b0;
        #1;
    endtask
    task automatic fire_check();
        `CHK("core", 1'b1, core)
        `CHK("periph", 1'b1, periph)
        `CHK("pin", 1'b0, rst_n)
        `CHK("expired", 1'b1, expired)
        `CHK("fire running", 1'b0, running)
        repeat (SWD_RST_PULSE_CYC - 1) @(posedge clk_in);
        #1 `CHK("core held", 1'b1, core)
        `CHK("periph held", 1'b1, periph)
        @(posedge clk_in);
        #1 `CHK("released", 1'b0, core)
        `CHK("pin released", 1'b1, rst_n)
        `CHK("expired stays", 1'b1, expired)
        op(1, 32'h0);
        `CHK("loaded", 1'b0, loaded)
        `CHK("running", 1'b0, running)
    endtask
    task automatic t_expire();
        op(1, 32'h0);
        `CHK("enable empty", 1'b0, running)
        op(0, 32'h1);
        op(1, 32'h0);
        tick();
        `CHK("count zero", 32'h0, count)
        `CHK("still running", 1'b1, running)
        @(posedge clk_in);
        #1 fire_check();
    endtask
    task automatic t_count_reload();
        op(0, 32'h0000_0005);
        `CHK("loaded", 1'b1, loaded)
        `CHK("count load", 32'h5, count)
        `CHK("armed idle", 1'b0, running)
        tick();
        `CHK("armed hold", 32'h5, count)
        op(1, 32'h0);
        `CHK("running", 1'b1, running)
        `CHK("expired clear", 1'b0, expired)
        repeat (3) tick();
        repeat (3) @(posedge clk_in);
        #1 `CHK("count step", 32'h2, count)
        op(3, 32'h0);
        `CHK("reload", 32'h5, count)
        op(0, 32'h0000_0007);
        `CHK("load running", 32'h7, count)
        tick();
        `CHK("step after load", 32'h6, count)
        op(3, 32'h0);
        `CHK("reload new", 32'h7, count)
        op(2, 32'h0);
        tick();
        `CHK("disabled hold", 32'h7, count)
        `CHK("not running", 1'b0, running)
    endtask
    task automatic t_zero_load();
        op(0, 32'h0);
        op(1, 32'h0);
        `CHK("running zero", 1'b1, running)
        @(posedge clk_in);
        #1 fire_check();
    endtask
    task automatic t_reset_mid();
        op(0, 32'h0000_0009);
        op(1, 32'h0);
        tick();
        `CHK("count before", 32'h8, count)
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 `CHK("rst count", 32'h0, count)
        `CHK("rst loaded", 1'b0, loaded)
        `CHK("rst running", 1'b0, running)
        `CHK("rst pin", 1'b1, rst_n)
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        op(1, 32'h0);
        `CHK("enable after rst", 1'b0, running)
        op(0, 32'h0000_0002);
        op(1, 32'h0);
        `CHK("run after rst", 1'b1, running)
        `CHK("count after rst", 32'h2, count)
    endtask
    task automatic close_out();
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        #1 `CHK("pin idle", 1'b1, rst_n)
        `CHK("count rst", 32'h0, count)
        `CHK("core idle", 1'b0, core)
        t_expire();
        t_count_reload();
        t_zero_load();
        t_reset_mid();
        close_out();
    end
endmodule
